/* src/bcrf_pkg.sv */
// Package with shared constants and types of the banked register file.
package bcrf_pkg;
    // Register counts and widths.
    localparam int BCRF_BANKS = 2;
    localparam int BCRF_BANK_REGS = 7;
    localparam int BCRF_WORD_W = 16;
    localparam int BCRF_BYTE_W = 8;
    localparam int BCRF_LONG_W = 32;
    // Register indices inside one bank.
    localparam logic [2:0] BCRF_IDX_DATA_ZERO = 3'h0;
    localparam logic [2:0] BCRF_IDX_DATA_ONE = 3'h1;
    localparam logic [2:0] BCRF_IDX_DATA_TWO = 3'h2;
    localparam logic [2:0] BCRF_IDX_DATA_THREE = 3'h3;
    localparam logic [2:0] BCRF_IDX_ADDR_ZERO = 3'h4;
    localparam logic [2:0] BCRF_IDX_ADDR_ONE = 3'h5;
    localparam logic [2:0] BCRF_IDX_FRAME_BASE = 3'h6;
    // Reset value of every register (none documented).
    localparam logic [15:0] BCRF_RESET_WORD = 16'h0000;
    // APB register map, byte addresses.
    localparam logic [11:0] BCRF_OFS_BANK_SEL = 12'h000;
    localparam logic [11:0] BCRF_OFS_STATUS = 12'h004;
    localparam logic [11:0] BCRF_OFS_REG_BASE = 12'h040;
    localparam logic [11:0] BCRF_OFS_REG_LIMIT = 12'h078;
    // Access widths used by the datapath port.
    typedef enum logic [1:0] {
        BCRF_SZ_WORD,
        BCRF_SZ_BYTE,
        BCRF_SZ_LONG
    } bcrf_size_t;
    // Datapath access request.
    typedef struct packed {
        logic wr;
        bcrf_size_t size;
        logic [2:0] idx;
        logic hi;
        logic [31:0] wdata;
    } bcrf_req_t;
endpackage : bcrf_pkg

/* src/bcrf_word.sv */
// One 16-bit register with independent byte-lane write enables.
`timescale 1ns/10ps
`default_nettype none
module bcrf_word
    import bcrf_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Write port.
    input wire logic [1:0] be_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Stored value.
    output logic [WIDTH-1:0] q_o
);
    localparam int HALF = WIDTH / 2;

    // Each lane stores only when its enable is set.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= BCRF_RESET_WORD[WIDTH-1:0];
        end else begin
            if (be_i[0]) q_o[HALF-1:0] <= wdata_i[HALF-1:0];
            if (be_i[1]) q_o[WIDTH-1:HALF] <= wdata_i[WIDTH-1:HALF];
        end
    end
endmodule // bcrf_word
`default_nettype wire

/* src/bcrf_top.sv */
// Banked processor register file with datapath port and APB debug access.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module bcrf_top
    import bcrf_pkg::*;
#(
    parameter int BANKS = BCRF_BANKS,
    parameter int REGS = BCRF_BANK_REGS
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Datapath access port.
    input wire logic dp_valid_i,
    input wire bcrf_req_t dp_req_i,
    output logic [31:0] dp_rdata_o,
    output logic dp_rvalid_o,
    // Bank selection from the flag register.
    input wire logic bank_flag_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Active bank indication.
    output logic bank_o
);
    // Storage: BANKS x REGS words.
    logic [15:0] q [BANKS*REGS];
    logic [1:0] be [BANKS*REGS];
    logic [15:0] wd [BANKS*REGS];
    logic sw_bank_en;
    logic sw_bank;
    logic apb_phase;

    // The active bank comes from the flag unless software forces it.
    wire act_bank = sw_bank_en ? sw_bank : bank_flag_i;
    wire dp_wr = dp_valid_i && dp_req_i.wr;
    wire [2:0] dp_idx = dp_req_i.idx;
    wire is_byte = dp_req_i.size == BCRF_SZ_BYTE;
    wire is_long = dp_req_i.size == BCRF_SZ_LONG;
    // Byte writes take effect only on data registers zero and one; byte reads work on every register.
    wire byte_ok = dp_idx == BCRF_IDX_DATA_ZERO || dp_idx == BCRF_IDX_DATA_ONE;
    // A pair is named by its low register: zero pairs with two, one with three.
    wire [2:0] long_hi_idx = (dp_idx == BCRF_IDX_DATA_ONE) ? BCRF_IDX_DATA_THREE : BCRF_IDX_DATA_TWO;
    wire [2:0] long_lo_idx = (dp_idx == BCRF_IDX_DATA_ONE) ? BCRF_IDX_DATA_ONE : BCRF_IDX_DATA_ZERO;
    wire [3:0] bank_base = act_bank ? 4'(REGS) : 4'h0;

    // APB decode of the register window.
    wire apb_acc = psel_i && penable_i;
    wire apb_wr = apb_acc && pwrite_i;
    wire in_regs = paddr_i >= BCRF_OFS_REG_BASE && paddr_i < BCRF_OFS_REG_LIMIT && paddr_i[1:0] == 2'h0;
    wire [11:0] reg_off = paddr_i - BCRF_OFS_REG_BASE;
    wire [3:0] apb_slot = reg_off[5:2];
    wire hit_sel = paddr_i == BCRF_OFS_BANK_SEL;
    wire hit_stat = paddr_i == BCRF_OFS_STATUS;
    wire apb_ok = hit_sel || hit_stat || in_regs;

    // Datapath read mux, word, byte and long forms.
    wire [15:0] rd_word = q[bank_base + 4'(dp_idx)];
    wire [15:0] rd_lhi = q[bank_base + 4'(long_hi_idx)];
    wire [15:0] rd_llo = q[bank_base + 4'(long_lo_idx)];
    wire [7:0] rd_byte = dp_req_i.hi ? rd_word[15:8] : rd_word[7:0];
    wire [31:0] next_dp_rdata = is_long ? {rd_lhi, rd_llo} :
        is_byte ? {24'h000000, rd_byte} : {16'h0000, rd_word};

    // Per-register write enables; the datapath wins over APB in one cycle.
    always_comb begin
        for (int i = 0; i < BANKS*REGS; i++) begin
            be[i] = 2'b00;
            wd[i] = 16'h0000;
            if (apb_wr && in_regs && !dp_wr && 4'(i) == apb_slot) begin
                be[i] = 2'b11;
                wd[i] = pwdata_i[15:0];
            end
            if (dp_wr && 4'(i) == bank_base + 4'(dp_idx) && !is_long) begin
                if (is_byte) begin
                    if (byte_ok) begin
                        be[i] = dp_req_i.hi ? 2'b10 : 2'b01;
                        wd[i] = {dp_req_i.wdata[7:0], dp_req_i.wdata[7:0]};
                    end
                end else begin
                    be[i] = 2'b11;
                    wd[i] = dp_req_i.wdata[15:0];
                end
            end
            if (dp_wr && is_long && 4'(i) == bank_base + 4'(long_hi_idx)) begin
                be[i] = 2'b11;
                wd[i] = dp_req_i.wdata[31:16];
            end
            if (dp_wr && is_long && 4'(i) == bank_base + 4'(long_lo_idx)) begin
                be[i] = 2'b11;
                wd[i] = dp_req_i.wdata[15:0];
            end
        end
    end

    // Seven visible registers exist as fourteen words: two banks of seven.
    generate
        for (genvar g = 0; g < BANKS*REGS; g++) begin : g_word
            bcrf_word #(.WIDTH(BCRF_WORD_W)) u_word (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .be_i(be[g]),
                .wdata_i(wd[g]),
                .q_o(q[g])
            );
        end
    endgenerate

    // APB read data and a one-wait-state answer, longer while a datapath write holds off an APB register-window write.
    wire [31:0] next_prdata = hit_sel ? {30'h0, sw_bank, sw_bank_en} :
        hit_stat ? {31'h0, act_bank} :
        in_regs ? {16'h0000, q[apb_slot]} : 32'h00000000;
    wire next_pready = apb_acc && !apb_phase && !(pwrite_i && in_regs && dp_wr);

    // Datapath read register.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_rdata_o <= 32'h00000000;
            dp_rvalid_o <= 1'b0;
            bank_o <= 1'b0;
        end else begin
            dp_rdata_o <= (dp_valid_i && !dp_req_i.wr) ? next_dp_rdata : dp_rdata_o;
            dp_rvalid_o <= dp_valid_i && !dp_req_i.wr;
            bank_o <= act_bank;
        end
    end

    // APB answer registers and the bank override.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            apb_phase <= 1'b0;
            sw_bank_en <= 1'b0;
            sw_bank <= 1'b0;
        end else begin
            pready_o <= next_pready;
            pslverr_o <= next_pready && !apb_ok;
            prdata_o <= next_pready ? next_prdata : 32'h00000000;
            apb_phase <= next_pready;
            if (apb_wr && hit_sel && next_pready) begin
                sw_bank_en <= pwdata_i[0];
                sw_bank <= pwdata_i[1];
            end
        end
    end
endmodule // bcrf_top
`default_nettype wire

/* sim/bcrf_assertions.sv */
// Checker of the register file port timing.
`timescale 1ns/10ps
`default_nettype none
module bcrf_assertions
    import bcrf_pkg::*;
(
    // Watched ports.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic dp_valid_i,
    input wire bcrf_req_t dp_req_i,
    input wire logic [31:0] dp_rdata_o,
    input wire logic dp_rvalid_o,
    input wire logic bank_flag_i,
    input wire logic bank_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // A word written to data register two and read back two cycles later.
    sequence rd_s;
        dp_valid_i && !dp_req_i.wr;
    endsequence
    sequence keep_s;
        dp_valid_i && dp_req_i.wr && dp_req_i.size == BCRF_SZ_WORD && dp_req_i.idx == 3'h2 && !psel_i
        ##2 rd_s ##0 (dp_req_i.size == BCRF_SZ_WORD && dp_req_i.idx == 3'h2 && $stable(bank_o) && $stable(bank_flag_i));
    endsequence
    read_answer_a: assert property (rd_s |=> dp_rvalid_o) else $error("read not answered");
    read_quiet_a: assert property (!(dp_valid_i && !dp_req_i.wr) |=> !dp_rvalid_o) else $error("stray answer");
    word_keep_a: assert property (keep_s |=> dp_rdata_o[15:0] == $past(dp_req_i.wdata[15:0], 3))
        else $error("word lost");
    byte_zero_a: assert property (rd_s ##0 dp_req_i.size == BCRF_SZ_BYTE |=> dp_rdata_o[31:8] == 24'h000000)
        else $error("byte read upper bits set");
    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
    ready_cause_a: assert property (pready_o |-> $past(penable_i)) else $error("ready unasked");
    err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    ready_bound_a: assert property ($rose(penable_i) && psel_i |-> ##[1:2] pready_o) else $error("ready late");
endmodule // bcrf_assertions
bind bcrf_top bcrf_assertions u_bcrf_assertions (.clk_sys_i, .rst_n_i, .dp_valid_i, .dp_req_i, .dp_rdata_o,
    .dp_rvalid_o, .bank_flag_i, .bank_o, .psel_i, .penable_i, .pready_o, .pslverr_o);
`default_nettype wire

/* sim/bcrf_dp_model.sv */
// Datapath model that issues register accesses.
`timescale 1ns/10ps
`default_nettype none
module bcrf_dp_model
    import bcrf_pkg::*;
(
    // Clock and answer.
    input wire logic clk_sys_i,
    input wire logic dp_rvalid_o,
    input wire logic [31:0] dp_rdata_o,
    // Request.
    output logic req_valid_o,
    output bcrf_req_t req_o
);
    // Idle request at time zero.
    initial begin
        req_valid_o = 1'h0;
        req_o = '0;
    end
    // One access; read data counts only while the answer pulse stands.
    task automatic acc(logic w, bcrf_size_t s, logic [2:0] i, logic h, logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys_i);
        req_valid_o <= 1'h1;
        req_o <= '{w, s, i, h, d};
        @(posedge clk_sys_i);
        req_valid_o <= 1'h0;
        req_o.wdata <= ~d; // Idle data does not keep the last value.
        #1 q = dp_rvalid_o ? dp_rdata_o : 32'hFFFFFFFF;
    endtask
endmodule // bcrf_dp_model
`default_nettype wire

/* sim/bcrf_top_test.sv */
// Self-checking bench of the banked register file.
`timescale 1ns/10ps
`default_nettype none
module bcrf_top_test;
    import bcrf_pkg::*;
    logic clk_sys_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic bank_flag_i = 1'h0;
    logic psel_i = 1'h0;
    logic penable_i = 1'h0;
    logic pwrite_i = 1'h0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, q, prdata_o, dp_rdata_o;
    logic pready_o, pslverr_o, dp_rvalid_o, dp_valid_i, e, bank_o;
    bcrf_req_t dp_req_i;
    int fails = 0;
    int comparisons = 0;
    // Clock and instances.
    always #20 clk_sys_i = ~clk_sys_i;
    bcrf_top u_bcrf_top (.clk_sys_i, .rst_n_i, .dp_valid_i, .dp_req_i, .dp_rdata_o, .dp_rvalid_o, .bank_flag_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .bank_o);
    bcrf_dp_model u_bcrf_dp_model (.clk_sys_i, .dp_rvalid_o, .dp_rdata_o, .req_valid_o(dp_valid_i), .req_o(dp_req_i));
    task automatic chk(string n, logic [31:0] x, logic [31:0] s);
        comparisons++;
        if (s !== x) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic dp(logic w, bcrf_size_t s, int i, logic h, logic [31:0] d);
        u_bcrf_dp_model.acc(w, s, i[2:0], h, d, q);
    endtask
    // One APB transfer, held until ready is sampled high.
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk_sys_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
        @(posedge clk_sys_i);
        penable_i <= 1'h1;
        // Only the watchdog ends a wait that never sees ready.
        do @(posedge clk_sys_i); while (pready_o !== 1'h1);
        {q, e} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'h0;
    endtask
    task automatic word_test;
        for (int i = 0; i < 7; i++) begin
            dp(1'h1, BCRF_SZ_WORD, i, 1'h0, 32'h1100 * i + 3);
            dp(1'h0, BCRF_SZ_WORD, i, 1'h0, 32'h0);
            chk("word", 32'h1100 * i + 3, {16'h0, q[15:0]});
        end
    endtask
    task automatic byte_test;
        for (int i = 0; i < 2; i++) begin
            dp(1'h1, BCRF_SZ_WORD, i, 1'h0, 32'hA5C3);
            dp(1'h1, BCRF_SZ_BYTE, i, 1'h1, 32'h7E);
            dp(1'h0, BCRF_SZ_WORD, i, 1'h0, 32'h0);
            chk("upper byte", 32'h7EC3, {16'h0, q[15:0]});
            dp(1'h1, BCRF_SZ_BYTE, i, 1'h0, 32'h19);
            dp(1'h0, BCRF_SZ_BYTE, i, 1'h0, 32'h0);
            chk("lower byte", 32'h19, q);
        end
    endtask
    task automatic long_test;
        dp(1'h1, BCRF_SZ_LONG, 0, 1'h0, 32'h12345678);
        dp(1'h1, BCRF_SZ_LONG, 1, 1'h0, 32'h9ABCDEF0);
        dp(1'h0, BCRF_SZ_WORD, 3, 1'h0, 32'h0);
        chk("pair upper", 32'h9ABC, {16'h0, q[15:0]});
        dp(1'h0, BCRF_SZ_LONG, 0, 1'h0, 32'h0);
        chk("pair", 32'h12345678, q);
    endtask
    task automatic bank_test;
        @(posedge clk_sys_i) bank_flag_i <= 1'h1;
        dp(1'h1, BCRF_SZ_WORD, 0, 1'h0, 32'hBEEF);
        apb(1'h0, 12'h05C, 32'h0);
        chk("other bank", 32'hBEEF, q);
        apb(1'h0, 12'h078, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        @(posedge clk_sys_i) bank_flag_i <= 1'h0;
        dp(1'h0, BCRF_SZ_WORD, 0, 1'h0, 32'h0);
        chk("first bank", 32'h5678, {16'h0, q[15:0]});
    endtask
    // Software override of the bank, APB register write and a refused byte write.
    task automatic override_test;
        apb(1'h1, 12'h000, 32'h3);
        chk("override error", 32'h0, {31'h0, e});
        apb(1'h0, 12'h000, 32'h0);
        chk("override", 32'h3, q);
        apb(1'h0, 12'h004, 32'h0);
        chk("status", 32'h1, q);
        chk("bank out", 32'h1, {31'h0, bank_o});
        dp(1'h0, BCRF_SZ_WORD, 0, 1'h0, 32'h0);
        chk("forced bank", 32'hBEEF, q);
        apb(1'h1, 12'h044, 32'hCAFE);
        apb(1'h1, 12'h000, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk("status cleared", 32'h0, q);
        dp(1'h0, BCRF_SZ_WORD, 1, 1'h0, 32'h0);
        chk("apb write", 32'hCAFE, q);
        dp(1'h1, BCRF_SZ_WORD, 2, 1'h0, 32'h1111);
        dp(1'h1, BCRF_SZ_BYTE, 2, 1'h1, 32'h22);
        dp(1'h0, BCRF_SZ_WORD, 2, 1'h0, 32'h0);
        chk("byte refused", 32'h1111, q);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence and watchdog.
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        word_test();
        byte_test();
        long_test();
        bank_test();
        override_test();
        tally_and_finish();
    end
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule // bcrf_top_test
`default_nettype wire
